// ### hw/tft_consts.vh
// constants of the twin flicker timer core: register map, fields, resets, timing
// assumes a 250 MHz core clock; cycle counts follow from the clock period
`ifndef TFT_CONSTS_VH
`define TFT_CONSTS_VH
`define TFT_CLK_NS 4
`define TFT_MS_NS 1000000
`define TFT_MS_CYCLES (`TFT_MS_NS / `TFT_CLK_NS)
`define TFT_DEB_SHORT_MS 1
`define TFT_DEB_LONG_MS 20
`define TFT_TENTH_YEAR_S 3155760
`define TFT_PV_MAX 20'hF423F
`define TFT_ALARM_RST 14'h0064
`define TFT_THOUSAND 10'h3E8
// register byte offsets
`define TFT_REG_CTRL 8'h00
`define TFT_REG_RANGE 8'h04
`define TFT_REG_OFF_SET 8'h08
`define TFT_REG_ON_SET 8'h0C
`define TFT_REG_LIMIT1 8'h10
`define TFT_REG_LIMIT2 8'h14
`define TFT_REG_ALARM 8'h18
`define TFT_REG_PV 8'h1C
`define TFT_REG_STATUS 8'h20
`define TFT_REG_CNT_TOTAL 8'h24
`define TFT_REG_CNT_ONE 8'h28
`define TFT_REG_CNT_TWO 8'h2C
`define TFT_REG_RUNTIME 8'h30
// control register fields
`define TFT_CTRL_ON_START 0
`define TFT_CTRL_DOWN 1
`define TFT_CTRL_SHORT_WIDTH 2
`define TFT_CTRL_SOURCING 3
`define TFT_CTRL_DUAL_LIMIT 4
`define TFT_CTRL_INV_ONE 5
`define TFT_CTRL_INV_TWO 6
`define TFT_CTRL_IND_LO 7
`define TFT_CTRL_IND_HI 8
`define TFT_CTRL_RETAIN 9
`define TFT_CTRL_RST 10'h000
// indicator modes
`define TFT_IND_RATIO 2'h0
`define TFT_IND_DARK 2'h1
`define TFT_IND_LIT 2'h2
`endif

// ### hw/tft_core.v
// twin flicker timer core: flicker output, ratio indicators, ON counts, run time
// assumes synchronous inputs, a plain register port and PWR_UP as the power-good level
//
// Summary of operation
// [R1] OFF and ON durations each use their own range, 0.001 s to 1 h units.
// [R2] Up mode shows elapsed time, down mode shows remaining time.
// [R3] Start-phase bit picks whether flicker starts in OFF or ON phase.
// [R4] One 20 ms or 1 ms minimum width filters start, reset and gate.
// [R5] One polarity bit selects sinking or sourcing for all inputs.
// [R6] Contacts are time-limit plus instantaneous, or two time-limit.
// [R7] Set values are clamped to their own limit, programmable 1 to 999999.
// [R8] Each output has its own inversion bit.
// [R9] Counting up, indicators light from the left per sixth reached.
// [R10] Indicators go dark when present value wraps 999999 to 0.
// [R11] Counting down, indicators turn off from the right per sixth.
// [R12] Ratio display disabled forces indicators all dark or all lit.
// [R13] Alarm threshold in thousands, 0 to 9999, reset 100, zero disables.
// [R14] Total ON count at or above threshold raises replacement error.
// [R15] Total and per-output ON counts are read-only, in thousands.
// [R16] Run time monitor is read-only, in tenths of a year.
// [R17] OFF start: rising start begins timing off, toggling each expiry.
// [R18] ON start: rising start begins timing on, toggling each expiry.
// [R19] Start already active begins timing at power-up or reset release.
// [R20] Retentive variant holds timing through power loss; basic one resets.
// [R21] User keeps ON and OFF durations at least 100 ms with contacts.
// [R22] Outside party holds reset or removes power for at least 0.1 s.
// [R23] Timing ticks come from a prescaler chosen by the active range.
//
// The address map and strobed register access were decided locally.
`include "tft_consts.vh"
module tft_core #(
	parameter MS_CYCLES = `TFT_MS_CYCLES,
	parameter TENTH_YEAR_S = `TFT_TENTH_YEAR_S
) (
	// clock and reset
	input wire CLK,
	input wire RSTN,
	// register port
	input wire [7:0] ADDR,
	input wire [31:0] WDATA,
	input wire WR,
	input wire RD,
	output reg [31:0] RDATA,
	// field inputs and power
	input wire START_PIN,
	input wire RESET_PIN,
	input wire GATE_PIN,
	input wire PWR_UP,
	// relay and indicator outputs
	output reg OUTPUT_ONE,
	output reg OUTPUT_TWO,
	output reg [5:0] INDICATORS,
	output reg REPLACEMENT_DUE_ERROR
);
	localparam ST_IDLE = 2'b01;
	localparam ST_RUN = 2'b10;

	reg [9:0] ctrl_q;
	reg [7:0] range_q;
	reg [19:0] off_set_q, on_set_q, limit1_q, limit2_q;
	reg [13:0] alarm_q;
	reg [1:0] state_q;
	reg phase_q;
	reg [19:0] el_q;
	reg wrap_q;
	reg [31:0] ms_cnt_q;
	reg [21:0] unit_cnt_q;
	reg [31:0] sec_cnt_q;
	reg [9:0] ms_in_s_q;
	reg [15:0] runtime_q;
	reg start_prev_q, reset_prev_q, pwr_prev_q;
	reg [9:0] lo_q [0:2];
	reg [13:0] k_q [0:2];
	wire [2:0] pin_raw = {GATE_PIN, RESET_PIN, START_PIN};
	wire [2:0] filt;

	// chatter filter, one per input, shared width and polarity
	wire [31:0] deb_cycles = ctrl_q[`TFT_CTRL_SHORT_WIDTH] ?
		MS_CYCLES * `TFT_DEB_SHORT_MS : MS_CYCLES * `TFT_DEB_LONG_MS; // R4
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : deb
			reg [31:0] cnt_q;
			reg lvl_q;
			wire act = pin_raw[g] ~^ ctrl_q[`TFT_CTRL_SOURCING]; // R5
			always @(posedge CLK or negedge RSTN)
			begin
				if (!RSTN)
				begin
					cnt_q <= 32'h0;
					lvl_q <= 1'b0;
				end
				else if (act == lvl_q)
					cnt_q <= 32'h0;
				else if (cnt_q + 32'h1 >= deb_cycles) // R4
				begin
					lvl_q <= act;
					cnt_q <= 32'h0;
				end
				else
					cnt_q <= cnt_q + 32'h1;
			end
			assign filt[g] = lvl_q;
		end
	endgenerate
	wire start_lvl = filt[0];
	wire reset_lvl = filt[1];
	wire gate_lvl = filt[2];

	// millisecond base and range prescaler
	wire ms_tick = (ms_cnt_q == MS_CYCLES - 1);
	wire running = (state_q == ST_RUN);
	wire [3:0] cur_range = phase_q ? range_q[7:4] : range_q[3:0]; // R1
	reg [21:0] unit_ms;
	always @*
	begin
		case (cur_range) // R23
			4'h0: unit_ms = 22'h000001;
			4'h1: unit_ms = 22'h00000A;
			4'h2: unit_ms = 22'h000064;
			4'h3: unit_ms = 22'h0003E8;
			4'h4: unit_ms = 22'h001770;
			4'h5: unit_ms = 22'h00EA60;
			4'h6: unit_ms = 22'h057E40;
			4'h7: unit_ms = 22'h36EE80;
			default: unit_ms = 22'h0003E8;
		endcase
	end
	wire timing = running && !gate_lvl && PWR_UP;
	wire unit_tick = timing && ms_tick && (unit_cnt_q + 22'h1 >= unit_ms); // R23

	wire [19:0] cur_set = phase_q ? on_set_q : off_set_q;
	wire expire = unit_tick && (el_q + 20'h1 >= cur_set);
	wire start_go = !reset_lvl && PWR_UP && ((start_lvl && !start_prev_q) ||
		(start_lvl && reset_prev_q) || (start_lvl && !pwr_prev_q)); // R19
	wire power_drop = !PWR_UP && !ctrl_q[`TFT_CTRL_RETAIN]; // R20

	wire [19:0] wlim1 = (WDATA[19:0] == 20'h0) ? 20'h1 :
		(WDATA[19:0] > `TFT_PV_MAX) ? `TFT_PV_MAX : WDATA[19:0];
	wire [19:0] wclip1 = (WDATA[19:0] > limit1_q) ? limit1_q : WDATA[19:0];
	wire [19:0] wclip2 = (WDATA[19:0] > limit2_q) ? limit2_q : WDATA[19:0];

	always @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			ctrl_q <= `TFT_CTRL_RST;
			range_q <= 8'h11;
			off_set_q <= 20'h0;
			on_set_q <= 20'h0;
			limit1_q <= `TFT_PV_MAX;
			limit2_q <= `TFT_PV_MAX;
			alarm_q <= `TFT_ALARM_RST;
		end
		else if (WR)
		begin
			case (ADDR)
				`TFT_REG_CTRL: ctrl_q <= WDATA[9:0];
				`TFT_REG_RANGE: range_q <= WDATA[7:0];
				`TFT_REG_OFF_SET: off_set_q <= wclip1; // R7
				`TFT_REG_ON_SET: on_set_q <= wclip2; // R7
				`TFT_REG_LIMIT1: limit1_q <= wlim1; // R7
				`TFT_REG_LIMIT2: limit2_q <= (WDATA[19:0] == 20'h0) ? 20'h1 :
					(WDATA[19:0] > `TFT_PV_MAX) ? `TFT_PV_MAX : WDATA[19:0];
				`TFT_REG_ALARM: alarm_q <= (WDATA[13:0] > 14'h270F) ? 14'h270F :
					WDATA[13:0]; // R13
				default: ctrl_q <= ctrl_q;
			endcase
		end
	end

	// flicker sequencer
	always @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			state_q <= ST_IDLE;
			phase_q <= 1'b0;
			el_q <= 20'h0;
			wrap_q <= 1'b0;
			ms_cnt_q <= 32'h0;
			unit_cnt_q <= 22'h0;
			start_prev_q <= 1'b0;
			reset_prev_q <= 1'b1;
			pwr_prev_q <= 1'b0;
		end
		else
		begin
			start_prev_q <= start_lvl;
			reset_prev_q <= reset_lvl;
			pwr_prev_q <= PWR_UP;
			ms_cnt_q <= ms_tick ? 32'h0 : ms_cnt_q + 32'h1;
			if (timing && ms_tick)
				unit_cnt_q <= unit_tick ? 22'h0 : unit_cnt_q + 22'h1;
			if (unit_tick)
				wrap_q <= (el_q == `TFT_PV_MAX); // R10
			case (state_q)
				ST_IDLE:
				begin
					if (start_go) // R17 R18
					begin
						state_q <= ST_RUN;
						phase_q <= ctrl_q[`TFT_CTRL_ON_START]; // R3
						el_q <= 20'h0;
						unit_cnt_q <= 22'h0;
					end
				end
				ST_RUN:
				begin
					if (reset_lvl || power_drop) // R20
					begin
						state_q <= ST_IDLE;
						phase_q <= 1'b0;
						el_q <= 20'h0;
						wrap_q <= 1'b0;
					end
					else if (expire) // R17 R18
					begin
						phase_q <= !phase_q;
						el_q <= 20'h0;
					end
					else if (unit_tick)
						el_q <= (el_q == `TFT_PV_MAX) ? 20'h0 : el_q + 20'h1;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// present value and indicators
	wire down = ctrl_q[`TFT_CTRL_DOWN];
	wire [19:0] pv = down ? cur_set - el_q : el_q; // R2
	wire [22:0] pv6 = {3'h0, pv} * 23'h6;
	reg [5:0] ind_d;
	integer k;
	always @*
	begin
		ind_d = 6'h0;
		for (k = 1; k <= 6; k = k + 1)
		begin
			if (down)
				ind_d[6 - k] = pv6 > {3'h0, cur_set} * (k - 1); // R11
			else
				ind_d[6 - k] = pv6 >= {3'h0, cur_set} * k; // R9
		end
		if (wrap_q)
			ind_d = 6'h0; // R10
		if (ctrl_q[`TFT_CTRL_IND_HI:`TFT_CTRL_IND_LO] == `TFT_IND_DARK)
			ind_d = 6'h00; // R12
		else if (ctrl_q[`TFT_CTRL_IND_HI:`TFT_CTRL_IND_LO] == `TFT_IND_LIT)
			ind_d = 6'h3F; // R12
	end

	// contact drive
	wire ctrl_on = running && phase_q;
	wire output_one_d = (ctrl_q[`TFT_CTRL_DUAL_LIMIT] ? ctrl_on : running) ^
		ctrl_q[`TFT_CTRL_INV_ONE]; // R6 R8
	wire output_two_d = ctrl_on ^ ctrl_q[`TFT_CTRL_INV_TWO]; // R8
	wire [2:0] ev = {output_two_d & !OUTPUT_TWO, output_one_d & !OUTPUT_ONE,
		(output_one_d & !OUTPUT_ONE) | (output_two_d & !OUTPUT_TWO)};

	// ON counts: slot 0 total, 1 output one, 2 output two
	wire [1:0] inc0 = {1'b0, ev[1]} + {1'b0, ev[2]};
	integer c;
	always @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			for (c = 0; c < 3; c = c + 1)
			begin
				lo_q[c] <= 10'h0;
				k_q[c] <= 14'h0;
			end
		end
		else
		begin
			for (c = 0; c < 3; c = c + 1)
			begin
				if (ev[c])
				begin
					if (lo_q[c] + ((c == 0) ? {8'h0, inc0} : 10'h1) >= `TFT_THOUSAND)
					begin
						lo_q[c] <= lo_q[c] + ((c == 0) ? {8'h0, inc0} : 10'h1) -
							`TFT_THOUSAND; // R15
						k_q[c] <= k_q[c] + 14'h1;
					end
					else
						lo_q[c] <= lo_q[c] + ((c == 0) ? {8'h0, inc0} : 10'h1);
				end
			end
		end
	end

	// powered run time in tenths of a year
	always @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			ms_in_s_q <= 10'h0;
			sec_cnt_q <= 32'h0;
			runtime_q <= 16'h0;
		end
		else if (PWR_UP && ms_tick)
		begin
			ms_in_s_q <= (ms_in_s_q == `TFT_THOUSAND - 10'h1) ? 10'h0 : ms_in_s_q + 10'h1;
			if (ms_in_s_q == `TFT_THOUSAND - 10'h1)
			begin
				if (sec_cnt_q + 32'h1 >= TENTH_YEAR_S) // R16
				begin
					sec_cnt_q <= 32'h0;
					runtime_q <= runtime_q + 16'h1;
				end
				else
					sec_cnt_q <= sec_cnt_q + 32'h1;
			end
		end
	end

	// registered outputs and read port
	always @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			OUTPUT_ONE <= 1'b0;
			OUTPUT_TWO <= 1'b0;
			INDICATORS <= 6'h0;
			REPLACEMENT_DUE_ERROR <= 1'b0;
			RDATA <= 32'h0;
		end
		else
		begin
			OUTPUT_ONE <= output_one_d;
			OUTPUT_TWO <= output_two_d;
			INDICATORS <= ind_d;
			REPLACEMENT_DUE_ERROR <= (alarm_q != 14'h0) && (k_q[0] >= alarm_q); // R13 R14
			RDATA <= 32'h0;
			if (RD)
			begin
				case (ADDR)
					`TFT_REG_CTRL: RDATA <= {22'h0, ctrl_q};
					`TFT_REG_RANGE: RDATA <= {24'h0, range_q};
					`TFT_REG_OFF_SET: RDATA <= {12'h0, off_set_q};
					`TFT_REG_ON_SET: RDATA <= {12'h0, on_set_q};
					`TFT_REG_LIMIT1: RDATA <= {12'h0, limit1_q};
					`TFT_REG_LIMIT2: RDATA <= {12'h0, limit2_q};
					`TFT_REG_ALARM: RDATA <= {18'h0, alarm_q};
					`TFT_REG_PV: RDATA <= {12'h0, pv}; // R2
					`TFT_REG_STATUS: RDATA <= {21'h0, REPLACEMENT_DUE_ERROR, INDICATORS,
						OUTPUT_TWO, OUTPUT_ONE, phase_q, running};
					`TFT_REG_CNT_TOTAL: RDATA <= {18'h0, k_q[0]}; // R15
					`TFT_REG_CNT_ONE: RDATA <= {18'h0, k_q[1]}; // R15
					`TFT_REG_CNT_TWO: RDATA <= {18'h0, k_q[2]}; // R15
					`TFT_REG_RUNTIME: RDATA <= {16'h0, runtime_q}; // R16
					default: RDATA <= 32'h0;
				endcase
			end
		end
	end
endmodule // tft_core

// ### hw/tft_unused_guard.v
// holds no logic: the whole timer core lives in tft_core.v

// ### testbench/tb.sv
// self-checking bench of the twin flicker timer core
// assumes a shortened millisecond count; power is driven by the bench
`include "tft_consts.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam MS = 10;
	reg CLK = 1'b0;
	reg RSTN = 1'b0;
	reg [7:0] ADDR = 8'h00;
	reg [31:0] WDATA = 32'h0;
	reg WR = 1'b0;
	reg RD = 1'b0;
	reg src = 1'b0;
	reg start_req = 1'b0;
	reg clear_req = 1'b0;
	reg pwr = 1'b1;
	wire [31:0] RDATA;
	wire START_PIN, RESET_PIN, GATE_PIN, OUTPUT_ONE, OUTPUT_TWO, REPLACEMENT_DUE_ERROR;
	wire [5:0] INDICATORS;
	integer error_cnt = 0;
	integer checks_done = 0;
	integer cyc = 0;
	integer n;
	reg [31:0] q;
	always #2 CLK = ~CLK;
	tft_core #(.MS_CYCLES(MS), .TENTH_YEAR_S(1)) tft_core_i (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .START_PIN(START_PIN),
		.RESET_PIN(RESET_PIN), .GATE_PIN(GATE_PIN), .PWR_UP(pwr), .OUTPUT_ONE(OUTPUT_ONE),
		.OUTPUT_TWO(OUTPUT_TWO), .INDICATORS(INDICATORS),
		.REPLACEMENT_DUE_ERROR(REPLACEMENT_DUE_ERROR));
	tft_field_model #(.HOLD(100 * MS)) tft_field_model_i (.CLK(CLK), .sourcing(src),
		.start_req(start_req), .clear_req(clear_req), .gate_act(1'b0),
		.START_PIN(START_PIN), .RESET_PIN(RESET_PIN), .GATE_PIN(GATE_PIN));
	task chk(input [31:0] got, input [31:0] exp);
	begin
		checks_done = checks_done + 1;
		if (got !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task wr(input [7:0] a, input [31:0] d);
	begin
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	end
	endtask
	task rdc(input [7:0] a, input [31:0] exp);
	begin
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 q = RDATA;
		chk(q, exp);
	end
	endtask
	task pulse(input s);
	begin
		@(posedge CLK);
		if (s) start_req <= 1'b1;
		else clear_req <= 1'b1;
		@(posedge CLK);
		start_req <= 1'b0;
		clear_req <= 1'b0;
	end
	endtask
	task wait_one(input lvl);
	begin
		n = 0;
		while (OUTPUT_ONE !== lvl && n < 2000)
		begin
			@(posedge CLK);
			#1 n = n + 1;
		end
	end
	endtask
	// cycles until relay two leaves lvl, capped
	task hold_len(input lvl);
	begin
		n = 0;
		while (OUTPUT_TWO === lvl && n < 3000)
		begin
			@(posedge CLK);
			#1 n = n + 1;
		end
	end
	endtask
	task t_regs;
	begin
		rdc(`TFT_REG_CTRL, 32'h0);
		rdc(`TFT_REG_RANGE, 32'h11);
		rdc(`TFT_REG_LIMIT2, 32'hF423F);
		rdc(`TFT_REG_ALARM, 32'h64);
		rdc(8'h34, 32'h0);
		wr(`TFT_REG_LIMIT1, 32'h0);
		rdc(`TFT_REG_LIMIT1, 32'h1);
		wr(`TFT_REG_LIMIT1, 32'h3);
		wr(`TFT_REG_OFF_SET, 32'h9);
		rdc(`TFT_REG_OFF_SET, 32'h3);
		wr(`TFT_REG_LIMIT1, 32'hF423F);
		wr(`TFT_REG_ALARM, 32'h3000);
		rdc(`TFT_REG_ALARM, 32'h270F);
		wr(`TFT_REG_ALARM, 32'h0);
		wr(`TFT_REG_CNT_TOTAL, 32'h5);
		rdc(`TFT_REG_CNT_TOTAL, 32'h0);
		chk(REPLACEMENT_DUE_ERROR, 32'h0);
		wr(`TFT_REG_RUNTIME, 32'h5);
		rdc(`TFT_REG_RUNTIME, 32'h0);
	end
	endtask
	task t_forced;
	begin
		wr(`TFT_REG_CTRL, 32'h80);
		repeat (8) @(posedge CLK);
		#1 chk(INDICATORS, 32'h0);
		wr(`TFT_REG_CTRL, 32'h100);
		repeat (8) @(posedge CLK);
		#1 chk(INDICATORS, 32'h3F);
	end
	endtask
	task t_flicker;
	begin
		wr(`TFT_REG_CTRL, 32'hC);
		src <= 1'b1;
		// off one 100 ms unit, on twelve 10 ms units: both at least 100 ms
		wr(`TFT_REG_RANGE, 32'h12);
		wr(`TFT_REG_OFF_SET, 32'h1);
		wr(`TFT_REG_ON_SET, 32'hC);
		repeat (2 * MS) @(posedge CLK);
		pulse(1'b1);
		wait_one(1'b1);
		chk(OUTPUT_ONE, 32'h1);
		chk(OUTPUT_TWO, 32'h0);
		hold_len(1'b0);
		hold_len(1'b1);
		chk(n, 120 * MS);
		hold_len(1'b0);
		chk(n, 100 * MS);
		wr(`TFT_REG_CTRL, 32'h1C);
		repeat (8) @(posedge CLK);
		#1 chk(OUTPUT_ONE, OUTPUT_TWO);
		wr(`TFT_REG_CTRL, 32'h3C);
		repeat (8) @(posedge CLK);
		#1 chk(OUTPUT_ONE, !OUTPUT_TWO);
	end
	endtask
	task t_restart;
	begin
		wr(`TFT_REG_CTRL, 32'hD);
		pulse(1'b0);
		repeat (15) @(posedge CLK);
		pulse(1'b1);
		wait_one(1'b0);
		chk(OUTPUT_ONE, 32'h0);
		wait_one(1'b1);
		chk(OUTPUT_TWO, 32'h1);
		// power loss drops a basic timer to idle, power return restarts it
		@(posedge CLK);
		pwr <= 1'b0;
		pulse(1'b1);
		repeat (20) @(posedge CLK);
		#1 chk(OUTPUT_ONE, 32'h0);
		@(posedge CLK);
		pwr <= 1'b1;
		wait_one(1'b1);
		chk(OUTPUT_ONE, 32'h1);
	end
	endtask
	task t_runtime;
	begin
		while (cyc < 10100)
			@(posedge CLK);
		rdc(`TFT_REG_RUNTIME, 32'h1);
	end
	endtask
	task report_and_stop;
	begin
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	initial
	begin
		repeat (6) @(posedge CLK);
		RSTN <= 1'b1;
		t_regs;
		t_forced;
		t_flicker;
		t_restart;
		t_runtime;
		report_and_stop;
	end
	always @(posedge CLK)
	begin
		cyc = cyc + 1;
		if (cyc == 12000)
		begin
			error_cnt = error_cnt + 1;
			report_and_stop;
		end
	end
endmodule // tb

// ### testbench/tft_core_monitor.sv
// port checker of the twin flicker timer core
// assumes a bind into tft_core; control writes are shadowed here
`include "tft_consts.vh"
module tft_core_monitor (
	// clock and reset
	input wire CLK,
	input wire RSTN,
	// register writes
	input wire [7:0] ADDR,
	input wire [31:0] WDATA,
	input wire WR,
	// field side
	input wire START_PIN,
	input wire OUTPUT_ONE,
	input wire OUTPUT_TWO,
	input wire [5:0] INDICATORS,
	input wire REPLACEMENT_DUE_ERROR
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [9:0] ctrl_q;
	reg [13:0] alarm_q;
	reg [2:0] age_q;
	wire quiet = age_q == 3'h7;
	wire [1:0] ind = ctrl_q[8:7];
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	always @(posedge CLK or negedge RSTN)
	if (!RSTN)
	begin
		ctrl_q <= `TFT_CTRL_RST;
		alarm_q <= `TFT_ALARM_RST;
		age_q <= 3'h0;
	end
	else
	begin
		if (WR && ADDR == `TFT_REG_ALARM)
			alarm_q <= (WDATA > 32'h270F) ? 14'h270F : WDATA[13:0];
		if (WR && ADDR == `TFT_REG_CTRL)
		begin
			ctrl_q <= WDATA[9:0];
			age_q <= 3'h0;
		end
		else if (!quiet)
			age_q <= age_q + 3'h1;
	end
	forced_dark_a: assert property (quiet && ind == `TFT_IND_DARK |-> INDICATORS == 6'h00)
		else $error("lamps lit while forced dark");
	forced_lit_a: assert property (quiet && ind == `TFT_IND_LIT |-> INDICATORS == 6'h3F)
		else $error("lamps dark while forced lit");
	lamp_order_a: assert property (INDICATORS inside {6'h00, 6'h20, 6'h30, 6'h38, 6'h3C,
		6'h3E, 6'h3F}) else $error("lamps not filled from the left");
	alarm_off_a: assert property ((alarm_q == 14'h0000)[*4] |-> !REPLACEMENT_DUE_ERROR)
		else $error("error with alarm disabled");
	twin_same_a: assert property (quiet && ctrl_q[4] && ctrl_q[5] == ctrl_q[6] |->
		OUTPUT_ONE == OUTPUT_TWO) else $error("time-limit contacts differ");
	twin_invert_a: assert property (quiet && ctrl_q[4] && ctrl_q[5] != ctrl_q[6] |->
		OUTPUT_ONE != OUTPUT_TWO) else $error("inversion not applied");
	start_filter_a: assert property (quiet && ctrl_q[2] && ctrl_q[5:4] == 2'h0 &&
		$rose(OUTPUT_ONE) |-> $past(START_PIN, 3) == ctrl_q[3] &&
		$past(START_PIN, 4) == ctrl_q[3]) else $error("start taken without stable input");
	start_phase_a: assert property (quiet && !ctrl_q[4] && !ctrl_q[5] &&
		$rose(OUTPUT_ONE) |-> OUTPUT_TWO == (ctrl_q[0] ^ ctrl_q[6]))
		else $error("wrong first phase");
	cover property ($rose(OUTPUT_ONE));
	cover property ($fell(OUTPUT_TWO));
	cover property (INDICATORS == 6'h3F);
endmodule // tft_core_monitor
bind tft_core tft_core_monitor tft_core_monitor_i (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .START_PIN(START_PIN), .OUTPUT_ONE(OUTPUT_ONE),
	.OUTPUT_TWO(OUTPUT_TWO), .INDICATORS(INDICATORS),
	.REPLACEMENT_DUE_ERROR(REPLACEMENT_DUE_ERROR));

// ### testbench/tft_field_model.sv
// field side: sensor contacts with one shared polarity
// assumes one-cycle requests on the core clock
module tft_field_model #(
	parameter HOLD = 30
) (
	// control
	input wire CLK,
	input wire sourcing,
	input wire start_req,
	input wire clear_req,
	input wire gate_act,
	// pins
	output wire START_PIN,
	output wire RESET_PIN,
	output wire GATE_PIN
);
	timeunit 1ns;
	timeprecision 1ps;
	integer start_cnt = 0;
	integer clear_cnt = 0;
	// contacts stay closed well past the filter width
	always @(posedge CLK)
	begin
		start_cnt <= start_req ? HOLD : (start_cnt > 0 ? start_cnt - 1 : 0);
		clear_cnt <= clear_req ? HOLD : (clear_cnt > 0 ? clear_cnt - 1 : 0);
	end
	assign START_PIN = (start_cnt > 0) ~^ sourcing;
	assign RESET_PIN = (clear_cnt > 0) ~^ sourcing;
	assign GATE_PIN = gate_act ~^ sourcing;
endmodule // tft_field_model
